// ---- aef_pkg.sv ----
// Package of offsets, field positions and reset values for the event flags
`default_nettype none
package aef_pkg;

	// ------------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------------
	localparam logic [7:0] AEF_FLAGS_OFS   = 8'h08;
	localparam logic [7:0] AEF_OPSTATE_OFS = 8'h09;

	// ------------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------------
	localparam int         AEF_NUM_FLAGS     = 3;
	localparam int         AEF_IN1_LOS_BIT   = 0;
	localparam int         AEF_IN1_VIOL_BIT  = 1;
	localparam int         AEF_IN2_LOS_BIT   = 2;
	localparam logic [2:0] AEF_FLAGS_RST     = 3'h0;
	localparam logic [4:0] AEF_FLAGS_PAD     = 5'h00;
	localparam logic [7:0] AEF_OPSTATE_RST   = 8'h41;
	localparam logic [7:0] AEF_RDATA_RST     = 8'h00;

	// Address match, shared by the write and the read decode
	function automatic logic aef_hit(input logic [7:0] addr,
		input logic [7:0] ofs);
		return addr == ofs;
	endfunction

endpackage
`default_nettype wire

// ---- aef_flag_if.sv ----
// Interface carrying set, clear and flag vectors to the flag bank
`timescale 1ns/100ps
`default_nettype none
interface aef_flag_if #(parameter int N = 3);
	logic [N-1:0] set;
	logic [N-1:0] clr;
	logic [N-1:0] flags;

	modport owner (input set, input clr, output flags);
	modport user  (output set, output clr, input flags);
endinterface
`default_nettype wire

// ---- aef_flag_bank.sv ----
// Bank of sticky write-one-to-clear event flags
`timescale 1ns/100ps
`default_nettype none
module aef_flag_bank
	import aef_pkg::*;
#(
	parameter int N = AEF_NUM_FLAGS
) (
	input  wire logic ref_clk_i,
	input  wire logic rst_n_i,
	input  wire logic ce_i,
	aef_flag_if.owner fb
);

	logic [N-1:0] flags_q;

	// ------------------------------------------------------------------
	// Sticky flags
	// ------------------------------------------------------------------
	// Set is ORed after the clear so a same-cycle event is never lost
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			flags_q <= N'(AEF_FLAGS_RST);
		end else if (ce_i) begin
			flags_q <= (flags_q & ~fb.clr) | fb.set;
		end
	end

	assign fb.flags = flags_q;

	// Flags hold while nothing clears them or the clock is frozen
	AST_FLAG_HOLD: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		(!ce_i || fb.clr == '0) |=> ((flags_q & $past(flags_q))
			== $past(flags_q)))
		else $error("flag dropped without a clear");

endmodule // aef_flag_bank
`default_nettype wire

// ---- aef_event_flags.sv ----
// Top of the input event flags and the operating-state status register
//
// Operation
// - Input two signal loss sets bit 2
// - Input one coding violation sets bit 1
// - Input one signal loss sets bit 0
// - Read-only operating state, resets to 0x41
// - Flags are bits 2:0 of the register at offset 0x08
`timescale 1ns/100ps
`default_nettype none
module aef_event_flags
	import aef_pkg::*;
(
	input  wire logic       ref_clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       ce_i,
	input  wire logic [7:0] reg_addr_i,
	input  wire logic       reg_wr_i,
	input  wire logic [7:0] reg_wdata_i,
	output var  logic [7:0] reg_rdata_o,
	input  wire logic       input_one_signal_loss_i,
	input  wire logic       input_one_coding_violation_i,
	input  wire logic       input_two_signal_loss_i,
	input  wire logic [7:0] dpll_state_i,
	output var  logic       input_one_signal_loss_flag_o,
	output var  logic       input_one_coding_violation_flag_o,
	output var  logic       input_two_signal_loss_flag_o
);

	// ------------------------------------------------------------------
	// Flag bank
	// ------------------------------------------------------------------
	aef_flag_if #(.N(AEF_NUM_FLAGS)) fb ();

	logic       wr_flags;
	logic [7:0] opstate_q;
	logic [7:0] rdata_q;

	// Only a write to the flag register clears; other offsets are ignored
	assign wr_flags = reg_wr_i && aef_hit(reg_addr_i, AEF_FLAGS_OFS);

	// Event inputs mapped onto their flag positions
	always_comb begin
		fb.set = '0;
		fb.set[AEF_IN2_LOS_BIT]  = input_two_signal_loss_i;
		fb.set[AEF_IN1_VIOL_BIT] = input_one_coding_violation_i;
		fb.set[AEF_IN1_LOS_BIT]  = input_one_signal_loss_i;
	end

	// Write of one clears; zeros and the upper bits are don't-care
	assign fb.clr = wr_flags ? reg_wdata_i[AEF_NUM_FLAGS-1:0] : '0;

	aef_flag_bank #(.N(AEF_NUM_FLAGS)) u_flag_bank (
		.ref_clk_i (ref_clk_i),
		.rst_n_i   (rst_n_i),
		.ce_i      (ce_i),
		.fb        (fb.owner)
	);

	// ------------------------------------------------------------------
	// Operating-state register
	// ------------------------------------------------------------------
	// Sampled every enabled cycle; writes to it are ignored
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			opstate_q <= AEF_OPSTATE_RST;
		end else if (ce_i) begin
			opstate_q <= dpll_state_i;
		end
	end

	// ------------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------------
	// Registered so the output comes from a flop; one cycle of latency
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_q <= AEF_RDATA_RST;
		end else if (ce_i) begin
			if (aef_hit(reg_addr_i, AEF_FLAGS_OFS)) begin
				rdata_q <= {AEF_FLAGS_PAD, fb.flags};
			end else if (aef_hit(reg_addr_i, AEF_OPSTATE_OFS)) begin
				rdata_q <= opstate_q;
			end else begin
				rdata_q <= AEF_RDATA_RST;
			end
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign reg_rdata_o                       = rdata_q;
	assign input_one_signal_loss_flag_o      = fb.flags[AEF_IN1_LOS_BIT];
	assign input_one_coding_violation_flag_o = fb.flags[AEF_IN1_VIOL_BIT];
	assign input_two_signal_loss_flag_o      = fb.flags[AEF_IN2_LOS_BIT];

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	// Building blocks: an event, a clean clear, a clear racing an event
	// A clean clear has no event on the same edge, so the flag must drop
	sequence s_viol_event;
		ce_i && input_one_coding_violation_i;
	endsequence

	sequence s_clear_in1_los;
		ce_i && wr_flags && reg_wdata_i[AEF_IN1_LOS_BIT]
			&& !input_one_signal_loss_i;
	endsequence

	sequence s_race_in2;
		ce_i && wr_flags && reg_wdata_i[AEF_IN2_LOS_BIT]
			&& input_two_signal_loss_i;
	endsequence

	sequence s_clear_in2;
		ce_i && wr_flags && reg_wdata_i[AEF_IN2_LOS_BIT]
			&& !input_two_signal_loss_i;
	endsequence

	sequence s_clear_viol;
		ce_i && wr_flags && reg_wdata_i[AEF_IN1_VIOL_BIT]
			&& !input_one_coding_violation_i;
	endsequence

	sequence s_race_in1_los;
		ce_i && wr_flags && reg_wdata_i[AEF_IN1_LOS_BIT]
			&& input_one_signal_loss_i;
	endsequence

	AST_IN2_LOS_SET: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		ce_i && input_two_signal_loss_i |=> input_two_signal_loss_flag_o)
		else $error("input two loss flag not set");

	AST_IN2_LOS_CLEAR: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		s_clear_in2 |=> !input_two_signal_loss_flag_o)
		else $error("input two loss flag not cleared");

	// Two steps: the event raises the flag, the next edge's clear drops it
	AST_IN1_VIOL_CLEAR: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		s_viol_event ##1 s_clear_viol
			|-> input_one_coding_violation_flag_o
			##1 !input_one_coding_violation_flag_o)
		else $error("violation flag set or clear wrong");

	AST_IN1_LOS_SET: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		ce_i && input_one_signal_loss_i |=> input_one_signal_loss_flag_o)
		else $error("input one loss flag not set");

	// Set and clear checks for the remaining flags
	AST_IN1_VIOL_SET: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		s_viol_event |=> input_one_coding_violation_flag_o)
		else $error("violation flag not set");

	AST_IN1_LOS_CLEAR: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		s_clear_in1_los |=> !input_one_signal_loss_flag_o)
		else $error("input one loss flag not cleared");

	// Second flag of the race, so both ends of the word are covered
	AST_RACE_IN2: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		s_race_in2 |=> input_two_signal_loss_flag_o)
		else $error("input two event lost to a same-cycle clear");

	// ------------------------------------------------------------------
	// Register reset, read, tracking, stray-write and freeze checks, and the input one loss race
	// ------------------------------------------------------------------
	// Reset value is checked on the first edge after release only
	AST_OPSTATE_RESET: assert property (@(posedge ref_clk_i)
		$rose(rst_n_i) |-> opstate_q == AEF_OPSTATE_RST)
		else $error("operating state reset value wrong");

	AST_OPSTATE_READ: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		ce_i && aef_hit(reg_addr_i, AEF_OPSTATE_OFS)
			|=> reg_rdata_o == $past(opstate_q))
		else $error("operating state read wrong");

	AST_FLAGS_READ: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		ce_i && aef_hit(reg_addr_i, AEF_FLAGS_OFS)
			|=> reg_rdata_o == {AEF_FLAGS_PAD, $past(fb.flags)})
		else $error("flag register read wrong");

	AST_SET_WINS: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		s_race_in1_los |=> input_one_signal_loss_flag_o)
		else $error("event lost to a same-cycle clear");

	// Register tracks the live state one cycle late; writes never reach it
	AST_OPSTATE_TRACK: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		ce_i |=> opstate_q == $past(dpll_state_i))
		else $error("operating state not tracking its input");

	// Unmapped offsets read as zero so software never sees stale data
	AST_UNMAPPED_READ: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		ce_i && !aef_hit(reg_addr_i, AEF_FLAGS_OFS)
			&& !aef_hit(reg_addr_i, AEF_OPSTATE_OFS)
			|=> reg_rdata_o == AEF_RDATA_RST)
		else $error("unmapped read not zero");

	// Writes to other offsets must leave every flag alone
	AST_STRAY_WRITE: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		ce_i && reg_wr_i && !wr_flags
			|=> (fb.flags & $past(fb.flags)) == $past(fb.flags))
		else $error("write elsewhere cleared a flag");

	// A low enable freezes every register of the block
	AST_FREEZE: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		!ce_i |=> $stable(reg_rdata_o) && $stable(opstate_q)
			&& $stable(fb.flags))
		else $error("state moved while the enable was low");

endmodule // aef_event_flags
`default_nettype wire

// ---- tb_aef_event_flags.sv ----
// Self-checking testbench for the input event flags block
`timescale 1ns/100ps
`default_nettype none
module tb_aef_event_flags;
	import aef_pkg::*;
	// ----------------------------------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------------------------------
	logic       ref_clk_i    = 1'b0;
	logic       rst_n_i      = 1'b0;
	logic       ce_i         = 1'b1;
	logic [7:0] reg_addr_i   = 8'h00;
	logic       reg_wr_i     = 1'b0;
	logic [7:0] reg_wdata_i  = 8'h00;
	logic [7:0] dpll_state_i = 8'h00;
	logic [2:0] ev           = 3'h0;
	logic [7:0] reg_rdata_o;
	logic [2:0] fl;
	int         n_mismatch   = 0;
	int         n_tests      = 0;
	int         cycles       = 0;

	aef_event_flags aef_event_flags_i (
		.ref_clk_i                         (ref_clk_i),
		.rst_n_i                           (rst_n_i),
		.ce_i                              (ce_i),
		.reg_addr_i                        (reg_addr_i),
		.reg_wr_i                          (reg_wr_i),
		.reg_wdata_i                       (reg_wdata_i),
		.reg_rdata_o                       (reg_rdata_o),
		.input_one_signal_loss_i           (ev[0]),
		.input_one_coding_violation_i      (ev[1]),
		.input_two_signal_loss_i           (ev[2]),
		.dpll_state_i                      (dpll_state_i),
		.input_one_signal_loss_flag_o      (fl[0]),
		.input_one_coding_violation_flag_o (fl[1]),
		.input_two_signal_loss_flag_o      (fl[2])
	);

	// 100 MHz clock
	always #5 ref_clk_i = ~ref_clk_i;

	// Hang guard, far above the fifty or so cycles the tests need
	always @(posedge ref_clk_i) begin
		cycles++;
		if (cycles == 2000) begin
			n_mismatch++;
			conclude;
		end
	end

	// ----------------------------------------------------------------
	// Access tasks; inputs move 1 ns after the rising edge
	// ----------------------------------------------------------------
	task automatic tick;
		@(posedge ref_clk_i);
		#1;
	endtask
	task automatic chk(input string nm, input logic [7:0] seen,
		input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = 1'b1;
		tick;
		reg_wr_i = 1'b0;
	endtask
	// Read data is registered, so it is checked one edge after the address
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		reg_addr_i = a;
		tick;
		chk("rdata", reg_rdata_o, e);
	endtask
	task automatic conclude;
		$display("tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (16) @(posedge ref_clk_i);
		#1;
		chk("rdata_rst", reg_rdata_o, AEF_RDATA_RST);
		chk("flags_rst", {5'h00, fl}, 8'h00);
		rst_n_i = 1'b1;
		rd(AEF_OPSTATE_OFS, AEF_OPSTATE_RST);
		dpll_state_i = 8'h5a;
		tick;
		rd(AEF_OPSTATE_OFS, 8'h5a);
		wr(AEF_OPSTATE_OFS, 8'hff);
		rd(AEF_OPSTATE_OFS, 8'h5a);
		rd(8'h33, 8'h00);
		// Each event alone, cleared with junk in the unused bits
		for (int b = 0; b < 3; b++) begin
			ev[b] = 1'b1;
			tick;
			ev[b] = 1'b0;
			chk("flag", {5'h0, fl}, 8'(1<<b));
			rd(AEF_FLAGS_OFS, 8'(1 << b));
			wr(AEF_FLAGS_OFS, 8'hf8 | 8'(1 << b));
			rd(AEF_FLAGS_OFS, 8'h00);
		end
		// Violation, then a clear on the very next edge
		ev = 3'h2;
		tick;
		ev = 3'h0;
		chk("viol_set", {5'h0, fl}, 8'h02);
		wr(AEF_FLAGS_OFS, 8'h02);
		chk("viol_clr", {5'h0, fl}, 8'h00);
		// All set, wrong-address write, then a partial clear
		ev = 3'h7;
		tick;
		ev = 3'h0;
		wr(AEF_OPSTATE_OFS, 8'h07);
		rd(AEF_FLAGS_OFS, 8'h07);
		wr(AEF_FLAGS_OFS, 8'h02);
		rd(AEF_FLAGS_OFS, 8'h05);
		wr(AEF_FLAGS_OFS, 8'h05);
		rd(AEF_FLAGS_OFS, 8'h00);
		// Event and clear in one cycle on two flags: both must survive
		ev = 3'h5;
		wr(AEF_FLAGS_OFS, 8'h05);
		ev = 3'h0;
		rd(AEF_FLAGS_OFS, 8'h05);
		wr(AEF_FLAGS_OFS, 8'h05);
		rd(AEF_FLAGS_OFS, 8'h00);
		// Clock enable low freezes the flags
		ce_i = 1'b0;
		ev = 3'h1;
		tick;
		ev = 3'h0;
		ce_i = 1'b1;
		chk("frozen", {5'h00, fl}, 8'h00);
		conclude;
	end
endmodule // tb_aef_event_flags
`default_nettype wire
